// file: fosr_bus.v
// Single asynchronous flash bus cycle generator (read or write)
`timescale 1ns/1ns
`default_nettype none
`include "fosr_map.vh"
module fosr_bus #(
    parameter PULSE_CYC = `FOSR_PULSE_CYC,
    parameter REC_CYC = `FOSR_REC_CYC
) (
    input wire clk,
    input wire rst,
    input wire start,
    input wire is_write,
    input wire [21:0] addr,
    input wire [15:0] wdata,
    output reg done_ff,
    output reg [15:0] rdata_ff,
    output reg [21:0] f_addr_ff,
    output reg [15:0] f_dq_o_ff,
    input wire [15:0] f_dq_i,
    output reg f_dq_oe_ff,
    output reg f_ce_n_ff,
    output reg f_oe_n_ff,
    output reg f_we_n_ff
);
    localparam S_IDLE = 3'b001;
    localparam S_ACT = 3'b010;
    localparam S_REC = 3'b100;

    reg [2:0] state_ff;
    reg [3:0] cnt_ff;
    reg wr_ff;

    // ****************************************************
    // Strobe sequencing; strobes always released between cycles
    // ****************************************************
    always @(posedge clk) begin
        if (rst) begin
            state_ff <= S_IDLE;
            cnt_ff <= 4'h0;
            wr_ff <= 1'b0;
            done_ff <= 1'b0;
            rdata_ff <= 16'h0000;
            f_addr_ff <= 22'h000000;
            f_dq_o_ff <= 16'h0000;
            f_dq_oe_ff <= 1'b0;
            f_ce_n_ff <= 1'b1;
            f_oe_n_ff <= 1'b1;
            f_we_n_ff <= 1'b1;
        end else begin
            done_ff <= 1'b0;
            case (state_ff)
                S_IDLE: begin
                    if (start) begin
                        state_ff <= S_ACT;
                        cnt_ff <= 4'h0;
                        wr_ff <= is_write;
                        f_addr_ff <= addr;
                        f_dq_o_ff <= wdata;
                        f_dq_oe_ff <= is_write;
                        f_ce_n_ff <= 1'b0;
                        f_oe_n_ff <= is_write;
                        f_we_n_ff <= ~is_write;
                    end
                end
                S_ACT: begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff == PULSE_CYC - 1) begin
                        // Sample at end of access, then deselect
                        if (!wr_ff) begin
                            rdata_ff <= f_dq_i;
                        end
                        f_ce_n_ff <= 1'b1;
                        f_oe_n_ff <= 1'b1;
                        f_we_n_ff <= 1'b1;
                        state_ff <= S_REC;
                        cnt_ff <= 4'h0;
                    end
                end
                S_REC: begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff == REC_CYC - 1) begin
                        f_dq_oe_ff <= 1'b0;
                        done_ff <= 1'b1;
                        state_ff <= S_IDLE;
                    end
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: fosr_chk.sv
// Checker on the host controller's register and flash pins
`timescale 1ns/1ns
`default_nettype none
module fosr_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata_ff,
    input wire logic [15:0] flash_dq_o,
    input wire logic flash_dq_oe,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Flags the data write that follows a program setup write
    logic pgm_data_ff;
    always @(posedge clk) begin
        if (rst) begin
            pgm_data_ff <= 1'b0;
        end else if ($rose(flash_we_n)) begin
            pgm_data_ff <= !pgm_data_ff && flash_dq_o == 16'h0040;
        end
    end
    // Strobe shape, spacing and bus ownership
    a_write_pulse: assert property ($fell(flash_we_n) |->
        !flash_we_n [*3] ##1 flash_we_n) else $error("write pulse length");
    a_read_pulse: assert property ($fell(flash_oe_n) |->
        !flash_oe_n [*3] ##1 flash_oe_n) else $error("read pulse length");
    a_read_gap: assert property ($rose(flash_oe_n) |->
        flash_oe_n [*3]) else $error("read recovery too short");
    a_strobe_excl: assert property (flash_we_n || flash_oe_n)
        else $error("both strobes low");
    a_chip_sel: assert property (!flash_we_n || !flash_oe_n |->
        !flash_ce_n) else $error("strobe without chip enable");
    a_read_float: assert property (!flash_oe_n |-> !flash_dq_oe)
        else $error("host drives data during read");
    a_cmd_lanes: assert property (!flash_we_n |-> flash_dq_oe &&
        (pgm_data_ff || flash_dq_o[15:8] == 8'h00))
        else $error("command lanes wrong");
    a_dq_release: assert property ($rose(flash_we_n) |->
        flash_dq_oe ##1 !flash_dq_oe) else $error("data release late");
    a_status_mask: assert property ($past(reg_rd) &&
        $past(reg_addr) == 4'h4 |-> !reg_rdata_ff[8])
        else $error("reserved status bit not masked");
    c_write: cover property ($fell(flash_we_n));
    c_read: cover property ($fell(flash_oe_n));
    c_idle_word: cover property ($past(reg_rd) && reg_rdata_ff[15]);
endmodule
bind fosr_top fosr_chk u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
`default_nettype wire

// file: fosr_flash_model.sv
// Behavioural flash device with status word
`timescale 1ns/1ns
`default_nettype none
module fosr_flash_model #(
    parameter [7:0] BUSY_POLLS = 8'h14,
    parameter [7:0] DEV_CODE = 8'h3C, // Arbitrary value
    parameter [7:0] MFR_CODE = 8'hC5, // Arbitrary value
    parameter [15:0] OTP_SEED = 16'h009B
) (
    input wire logic clk,
    input wire logic pe,
    input wire logic [21:0] flash_addr,
    input wire logic [15:0] flash_dq_o,
    output logic [15:0] flash_dq_i,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n
);
    logic [7:0] st_ff = 8'h00;
    logic [7:0] cnt_ff = 8'h00;
    logic [7:0] first_ff = 8'h00;
    logic [1:0] mode_ff = 2'h0;
    logic prog_ff = 1'b0;
    logic prot_ff = 1'b0;
    logic we_l_ff = 1'b1;
    logic oe_l_ff = 1'b1;
    logic [15:0] dq_ff = 16'h0000;
    wire logic [7:0] cb;
    assign cb = flash_dq_o[7:0];
    assign flash_dq_i = dq_ff;
    // Command decode on write strobe, answers on fresh read strobe
    always @(posedge clk) begin
        we_l_ff <= flash_we_n;
        oe_l_ff <= flash_oe_n;
        if (!flash_ce_n && !flash_we_n && we_l_ff) begin
            first_ff <= 8'h00;
            mode_ff <= 2'h1;
            if ({first_ff, cb} == 16'h20D0) begin
                prog_ff <= 1'b0;
                if (!pe) st_ff <= st_ff | 8'h28;
                else if (prot_ff) st_ff <= st_ff | 8'h22;
                else cnt_ff <= BUSY_POLLS;
            end else if (first_ff == 8'h40) begin
                prog_ff <= 1'b1;
                if (!pe) st_ff <= st_ff | 8'h18;
                else if (prot_ff) st_ff <= st_ff | 8'h12;
                else cnt_ff <= BUSY_POLLS;
            end else if (first_ff == 8'h60) begin
                // Protect on 01h, unprotect on any other byte (D0h included); whole array at once
                prot_ff <= (cb == 8'h01);
                cnt_ff <= BUSY_POLLS;
            end else if (first_ff != 8'h00) begin
                st_ff <= st_ff | 8'h30;
            end else case (cb)
                8'h70: mode_ff <= 2'h1;
                8'h50: st_ff <= st_ff & 8'h44;
                8'h90: mode_ff <= 2'h2;
                8'hFF: mode_ff <= 2'h0;
                8'hB0: if (cnt_ff != 8'h00) begin
                    cnt_ff <= 8'h02;
                    st_ff <= st_ff | (prog_ff ? 8'h04 :
                        8'h40);
                end
                8'hD0: if (st_ff[6] | st_ff[2]) begin
                    st_ff <= st_ff & 8'hBB;
                    cnt_ff <= BUSY_POLLS;
                end
                default: first_ff <= cb;
            endcase
        end
        if (!flash_ce_n && !flash_oe_n && oe_l_ff) begin
            if (mode_ff == 2'h1 && cnt_ff != 8'h00) begin
                cnt_ff <= cnt_ff - 8'h01;
                dq_ff <= {9'h000, ~dq_ff[6:0]};
            end else if (mode_ff == 2'h1)
                dq_ff <= {9'h001, st_ff[6:1], ~dq_ff[0]};
            else if (mode_ff == 2'h2 && flash_addr[8])
                dq_ff <= {11'h000, flash_addr[4:0]} ^ OTP_SEED;
            else if (mode_ff == 2'h2)
                dq_ff <= {8'h00, flash_addr[21:1] == 21'h1 ? DEV_CODE : MFR_CODE};
            else
                dq_ff <= flash_addr[15:0] ^ 16'h5A5A;
        end else if (flash_ce_n || flash_oe_n)
            dq_ff <= ~dq_ff;
    end
endmodule
`default_nettype wire

// file: fosr_map.vh
// Constants for the flash status-polling controller: map, fields, timing
`ifndef FOSR_MAP_VH
`define FOSR_MAP_VH

// ****************************************************
// Software register offsets (4-bit word index)
// ****************************************************
`define FOSR_REG_CTRL 4'h0
`define FOSR_REG_ADDR 4'h1
`define FOSR_REG_DATA 4'h2
`define FOSR_REG_CMD 4'h3
`define FOSR_REG_STATUS 4'h4
`define FOSR_REG_RESULT 4'h5

// ****************************************************
// Control and status fields
// ****************************************************
`define FOSR_CTRL_PEN 0
`define FOSR_CTRL_BYTE 1
`define FOSR_ST_BUSY 0
`define FOSR_ST_PEND 1
`define FOSR_ST_ERR 2
`define FOSR_ST_TMO 3

// ****************************************************
// Flash status word bits
// ****************************************************
`define FOSR_SB_IDLE 7
`define FOSR_SB_ESUSP 6
`define FOSR_SB_EFAIL 5
`define FOSR_SB_PFAIL 4
`define FOSR_SB_ENERR 3
`define FOSR_SB_PSUSP 2
`define FOSR_SB_PROT 1
`define FOSR_SB_RSVD 0
`define FOSR_STAT_MASK 8'hFE

// ****************************************************
// Operation codes written to the command register
// ****************************************************
`define FOSR_OP_RDSTAT 4'h0
`define FOSR_OP_CLR 4'h1
`define FOSR_OP_PGM 4'h2
`define FOSR_OP_ERS 4'h3
`define FOSR_OP_SUSP 4'h4
`define FOSR_OP_RES 4'h5
`define FOSR_OP_PROT 4'h6
`define FOSR_OP_UNPROT 4'h7
`define FOSR_OP_ID 4'h8
`define FOSR_OP_OTP 4'h9
`define FOSR_OP_ARRAY 4'hA

// ****************************************************
// Flash command bytes
// ****************************************************
`define FOSR_FC_RDSTAT 8'h70
`define FOSR_FC_CLR 8'h50
`define FOSR_FC_PGM 8'h40
`define FOSR_FC_ERS 8'h20
`define FOSR_FC_SUSP 8'hB0
`define FOSR_FC_CONF 8'hD0
`define FOSR_FC_PROT 8'h60
`define FOSR_FC_PROT2 8'h01
`define FOSR_FC_ID 8'h90
`define FOSR_FC_ARRAY 8'hFF

// ****************************************************
// Timing
// ****************************************************
`define FOSR_CLK_MHZ 25
`define FOSR_PGM_SUSP_US 20
`define FOSR_ERS_SUSP_US 25
`define FOSR_PGM_SUSP_CYC (`FOSR_PGM_SUSP_US * `FOSR_CLK_MHZ)
`define FOSR_ERS_SUSP_CYC (`FOSR_ERS_SUSP_US * `FOSR_CLK_MHZ)
`define FOSR_PULSE_CYC 3
`define FOSR_REC_CYC 1
`define FOSR_OTP_A8 8

`endif

// file: fosr_top.v
// Host controller issuing flash operations and polling the status word
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "fosr_map.vh"
module fosr_top #(
    parameter PULSE_CYC = `FOSR_PULSE_CYC,
    parameter REC_CYC = `FOSR_REC_CYC,
    parameter PGM_SUSP_CYC = `FOSR_PGM_SUSP_CYC,
    parameter ERS_SUSP_CYC = `FOSR_ERS_SUSP_CYC
) (
    input wire clk,
    input wire rst,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_ff,
    output wire [21:0] flash_addr,
    output wire [15:0] flash_dq_o,
    input wire [15:0] flash_dq_i,
    output wire flash_dq_oe,
    output wire flash_ce_n,
    output wire flash_oe_n,
    output wire flash_we_n,
    output reg program_erase_enable_input_ff
);
    localparam S_IDLE = 8'b00000001;
    localparam S_CLR = 8'b00000010;
    localparam S_W1 = 8'b00000100;
    localparam S_W2 = 8'b00001000;
    localparam S_POLL = 8'b00010000;
    localparam S_CHK = 8'b00100000;
    localparam S_RD = 8'b01000000;
    localparam S_WAIT = 8'b10000000;

    reg [7:0] state_ff;
    reg [7:0] ret_ff;
    reg [3:0] op_ff;
    reg byte_mode_ff;
    reg [21:0] addr_ff;
    reg [15:0] data_ff;
    reg busy_ff;
    reg pend_susp_ff;
    reg err_ff;
    reg tmo_ff;
    reg erase_kind_ff;
    reg susp_act_ff;
    reg [10:0] susp_cnt_ff;
    reg [7:0] stat_ff;
    reg [15:0] res_ff;
    reg bus_start_ff;
    reg bus_we_ff;
    reg [21:0] bus_addr_ff;
    reg [15:0] bus_wdata_ff;
    wire bus_done;
    wire [15:0] bus_rdata;
    wire cmd_wr;
    wire op_ok;

    // ****************************************************
    // Decode helpers
    // ****************************************************
    function [7:0] first_code;
        input [3:0] op;
        begin
            case (op)
                `FOSR_OP_RDSTAT: first_code = `FOSR_FC_RDSTAT;
                `FOSR_OP_CLR: first_code = `FOSR_FC_CLR;
                `FOSR_OP_PGM: first_code = `FOSR_FC_PGM;
                `FOSR_OP_ERS: first_code = `FOSR_FC_ERS;
                `FOSR_OP_SUSP: first_code = `FOSR_FC_SUSP;
                `FOSR_OP_RES: first_code = `FOSR_FC_CONF;
                `FOSR_OP_PROT: first_code = `FOSR_FC_PROT;
                `FOSR_OP_UNPROT: first_code = `FOSR_FC_PROT;
                `FOSR_OP_ID: first_code = `FOSR_FC_ID;
                `FOSR_OP_OTP: first_code = `FOSR_FC_ID;
                default: first_code = `FOSR_FC_ARRAY;
            endcase
        end
    endfunction

    // Operations that alter the array or protection
    function is_modify;
        input [3:0] op;
        begin
            is_modify = (op == `FOSR_OP_PGM) || (op == `FOSR_OP_ERS) ||
                (op == `FOSR_OP_PROT) || (op == `FOSR_OP_UNPROT);
        end
    endfunction

    // Byte-wide OTP address: A8 high, index/2 on A4..A1, index[0] on A0
    function [21:0] otp_addr;
        input [4:0] idx;
        begin
            otp_addr = 22'h000000;
            otp_addr[`FOSR_OTP_A8] = 1'b1;
            otp_addr[4:1] = idx[4:1];
            otp_addr[0] = idx[0];
        end
    endfunction

    assign cmd_wr = reg_wr && (reg_addr == `FOSR_REG_CMD);
    assign op_ok = (reg_wdata[3:0] <= `FOSR_OP_ARRAY);

    // ****************************************************
    // Operation sequencer
    // ****************************************************
    always @(posedge clk) begin
        if (rst) begin
            state_ff <= S_IDLE;
            ret_ff <= S_IDLE;
            op_ff <= `FOSR_OP_RDSTAT;
            busy_ff <= 1'b0;
            pend_susp_ff <= 1'b0;
            err_ff <= 1'b0;
            tmo_ff <= 1'b0;
            erase_kind_ff <= 1'b0;
            susp_act_ff <= 1'b0;
            susp_cnt_ff <= 11'h000;
            stat_ff <= 8'h00;
            res_ff <= 16'h0000;
            bus_start_ff <= 1'b0;
            bus_we_ff <= 1'b0;
            bus_addr_ff <= 22'h000000;
            bus_wdata_ff <= 16'h0000;
        end else begin
            bus_start_ff <= 1'b0;
            // Suspend timer runs from the suspend write onward
            if (susp_act_ff) begin
                susp_cnt_ff <= susp_cnt_ff + 11'h001;
            end
            // Suspend asked during a busy poll; serviced at next check
            if (cmd_wr && busy_ff && reg_wdata[3:0] == `FOSR_OP_SUSP) begin
                pend_susp_ff <= 1'b1;
            end
            case (state_ff)
                S_IDLE: begin
                    if (cmd_wr && op_ok) begin
                        op_ff <= reg_wdata[3:0];
                        busy_ff <= 1'b1;
                        tmo_ff <= 1'b0;
                        // Stale errors would fail the new operation
                        if (is_modify(reg_wdata[3:0]) && err_ff) begin
                            state_ff <= S_CLR;
                        end else begin
                            state_ff <= S_W1;
                        end
                    end
                end
                S_CLR: begin
                    bus_start_ff <= 1'b1;
                    bus_we_ff <= 1'b1;
                    bus_wdata_ff <= {8'h00, `FOSR_FC_CLR};
                    err_ff <= 1'b0;
                    stat_ff <= 8'h00;
                    ret_ff <= S_W1;
                    state_ff <= S_WAIT;
                end
                S_W1: begin
                    bus_start_ff <= 1'b1;
                    bus_we_ff <= 1'b1;
                    bus_addr_ff <= addr_ff;
                    bus_wdata_ff <= {8'h00, first_code(op_ff)};
                    state_ff <= S_WAIT;
                    if (is_modify(op_ff)) begin
                        erase_kind_ff <= (op_ff == `FOSR_OP_ERS) ||
                            (op_ff == `FOSR_OP_UNPROT);
                        ret_ff <= S_W2;
                    end else if (op_ff == `FOSR_OP_CLR) begin
                        err_ff <= 1'b0;
                        stat_ff <= 8'h00;
                        ret_ff <= S_IDLE;
                    end else if (op_ff == `FOSR_OP_SUSP) begin
                        susp_act_ff <= 1'b1;
                        susp_cnt_ff <= 11'h000;
                        ret_ff <= S_POLL;
                    end else if (op_ff == `FOSR_OP_RDSTAT ||
                            op_ff == `FOSR_OP_RES) begin
                        ret_ff <= S_POLL;
                    end else begin
                        ret_ff <= S_RD;
                    end
                end
                S_W2: begin
                    bus_start_ff <= 1'b1;
                    bus_we_ff <= 1'b1;
                    bus_addr_ff <= (op_ff == `FOSR_OP_UNPROT) ?
                        22'h000000 : addr_ff;
                    case (op_ff)
                        `FOSR_OP_PGM: bus_wdata_ff <= data_ff;
                        `FOSR_OP_PROT:
                            bus_wdata_ff <= {8'h00, `FOSR_FC_PROT2};
                        default: bus_wdata_ff <= {8'h00, `FOSR_FC_CONF};
                    endcase
                    // Device reads back status without a status command
                    ret_ff <= S_POLL;
                    state_ff <= S_WAIT;
                end
                S_POLL: begin
                    // Fresh strobe each poll refreshes the word
                    bus_start_ff <= 1'b1;
                    bus_we_ff <= 1'b0;
                    bus_addr_ff <= 22'h000000;
                    ret_ff <= S_CHK;
                    state_ff <= S_WAIT;
                end
                S_CHK: begin
                    if (bus_rdata[`FOSR_SB_IDLE]) begin
                        // Other bits only valid once idle
                        stat_ff <= bus_rdata[7:0] & `FOSR_STAT_MASK;
                        err_ff <= bus_rdata[`FOSR_SB_EFAIL] |
                            bus_rdata[`FOSR_SB_PFAIL] |
                            bus_rdata[`FOSR_SB_ENERR] |
                            bus_rdata[`FOSR_SB_PROT];
                        susp_act_ff <= 1'b0;
                        if (!cmd_wr) begin
                            pend_susp_ff <= 1'b0;
                        end
                        busy_ff <= 1'b0;
                        state_ff <= S_IDLE;
                    end else if (pend_susp_ff && !susp_act_ff) begin
                        // Busy bits float; issue the suspend straight away
                        op_ff <= `FOSR_OP_SUSP;
                        if (!cmd_wr) begin
                            pend_susp_ff <= 1'b0;
                        end
                        state_ff <= S_W1;
                    end else begin
                        if (susp_act_ff && susp_cnt_ff >= (erase_kind_ff ?
                                ERS_SUSP_CYC[10:0] : PGM_SUSP_CYC[10:0])) begin
                            tmo_ff <= 1'b1;
                            susp_act_ff <= 1'b0;
                        end
                        state_ff <= S_POLL;
                    end
                end
                S_RD: begin
                    bus_start_ff <= 1'b1;
                    bus_we_ff <= 1'b0;
                    if (op_ff == `FOSR_OP_OTP) begin
                        bus_addr_ff <= otp_addr(addr_ff[4:0]);
                    end else if (op_ff == `FOSR_OP_ID) begin
                        bus_addr_ff <= {addr_ff[21:1], 1'b0};
                    end else begin
                        bus_addr_ff <= addr_ff;
                    end
                    ret_ff <= S_IDLE;
                    state_ff <= S_WAIT;
                end
                S_WAIT: begin
                    if (bus_done) begin
                        state_ff <= ret_ff;
                        if (ret_ff == S_IDLE) begin
                            busy_ff <= 1'b0;
                            if (op_ff == `FOSR_OP_ID ||
                                    (op_ff == `FOSR_OP_OTP && byte_mode_ff)) begin
                                res_ff <= {8'h00, bus_rdata[7:0]};
                            end else if (op_ff != `FOSR_OP_CLR) begin
                                res_ff <= bus_rdata;
                            end
                        end
                    end
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

    // ****************************************************
    // Software registers
    // ****************************************************
    always @(posedge clk) begin
        if (rst) begin
            program_erase_enable_input_ff <= 1'b0;
            byte_mode_ff <= 1'b0;
            addr_ff <= 22'h000000;
            data_ff <= 16'h0000;
            reg_rdata_ff <= 32'h00000000;
        end else begin
            if (reg_wr && reg_addr == `FOSR_REG_CTRL) begin
                program_erase_enable_input_ff <= reg_wdata[`FOSR_CTRL_PEN];
                byte_mode_ff <= reg_wdata[`FOSR_CTRL_BYTE];
            end
            if (reg_wr && reg_addr == `FOSR_REG_ADDR && !busy_ff) begin
                addr_ff <= reg_wdata[21:0];
            end
            if (reg_wr && reg_addr == `FOSR_REG_DATA && !busy_ff) begin
                data_ff <= reg_wdata[15:0];
            end
            reg_rdata_ff <= 32'h00000000;
            if (reg_rd) begin
                case (reg_addr)
                    `FOSR_REG_CTRL: reg_rdata_ff <= {30'h00000000,
                        byte_mode_ff, program_erase_enable_input_ff};
                    `FOSR_REG_ADDR: reg_rdata_ff <= {10'h000, addr_ff};
                    `FOSR_REG_DATA: reg_rdata_ff <= {16'h0000, data_ff};
                    `FOSR_REG_STATUS: reg_rdata_ff <= {16'h0000, stat_ff,
                        4'h0, tmo_ff, err_ff, pend_susp_ff, busy_ff};
                    `FOSR_REG_RESULT: reg_rdata_ff <= {16'h0000, res_ff};
                    default: reg_rdata_ff <= 32'h00000000;
                endcase
            end
        end
    end

    // Pin-level cycle generator
    fosr_bus #(
        .PULSE_CYC(PULSE_CYC),
        .REC_CYC(REC_CYC)
    ) u_bus (
        .clk(clk),
        .rst(rst),
        .start(bus_start_ff),
        .is_write(bus_we_ff),
        .addr(bus_addr_ff),
        .wdata(bus_wdata_ff),
        .done_ff(bus_done),
        .rdata_ff(bus_rdata),
        .f_addr_ff(flash_addr),
        .f_dq_o_ff(flash_dq_o),
        .f_dq_i(flash_dq_i),
        .f_dq_oe_ff(flash_dq_oe),
        .f_ce_n_ff(flash_ce_n),
        .f_oe_n_ff(flash_oe_n),
        .f_we_n_ff(flash_we_n)
    );
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the flash status-polling controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk, rst, reg_wr, reg_rd;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, d;
    wire [31:0] rdata;
    wire [21:0] fa;
    wire [15:0] fdo, fdi;
    wire dq_oe, ce_n, oe_n, we_n, pe;
    int fail_count = 0;
    int n_compared = 0;
    fosr_top DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_ff(rdata), .flash_addr(fa), .flash_dq_o(fdo),
        .flash_dq_i(fdi), .flash_dq_oe(dq_oe), .flash_ce_n(ce_n),
        .flash_oe_n(oe_n), .flash_we_n(we_n),
        .program_erase_enable_input_ff(pe));
    fosr_flash_model u_flash (.clk(clk), .pe(pe), .flash_addr(fa),
        .flash_dq_o(fdo), .flash_dq_i(fdi), .flash_ce_n(ce_n),
        .flash_oe_n(oe_n), .flash_we_n(we_n));
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Register bus cycles
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Issue an op and poll until busy drops, bounded
    task automatic run(input logic [3:0] c);
        wr(4'h3, {28'h0, c});
        repeat (2) @(posedge clk);
        rd(4'h4);
        for (int i = 0; i < 600 && d[0] !== 1'b0; i++) rd(4'h4);
        chk({31'h0, d[0]}, 32'h0);
        if (d[0] !== 1'b0) conclude();
    endtask
    task automatic t_suspend(input logic [3:0] c, input logic [31:0] e);
        wr(4'h3, {28'h0, c});
        rd(4'h4);
        run(4'h4);
        chk(d & 32'hFF0D, e);
        run(4'h5);
        chk(d & 32'hFF0D, 32'h8000);
    endtask
    // Protect, erase a protected block, clear, unprotect, array read
    task automatic t_protect();
        run(4'h6);
        chk(d, 32'h8000);
        run(4'h3);
        chk(d, 32'hA204);
        run(4'h1);
        chk(d, 32'h0);
        run(4'h7);
        chk(d, 32'h8000);
        run(4'hA);
        rd(4'h5);
        chk(d, 32'h5A4B);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(4'h4);
        chk(d, 32'h0);
        rd(4'hF);
        chk(d, 32'h0);
        wr(4'h1, 32'h123);
        wr(4'h2, 32'h5A5A);
        run(4'h2);
        chk(d, 32'h9804);
        run(4'h0);
        chk(d, 32'h9804);
        run(4'h3);
        chk(d, 32'hA804);
        wr(4'h0, 32'h1);
        run(4'h2);
        chk(d, 32'h8000);
        t_suspend(4'h3, 32'hC000);
        t_suspend(4'h2, 32'h8400);
        wr(4'h1, 32'h3);
        run(4'h8);
        rd(4'h5);
        chk(d, 32'h3C);
        wr(4'h0, 32'h3);
        wr(4'h1, 32'h11);
        run(4'h9);
        rd(4'h5);
        chk(d, 32'h8A);
        t_protect();
        conclude();
    end
endmodule
`default_nettype wire
